// [src/pes_pkg.sv]
package pes_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Register map and fields.
    localparam logic [3:0]  CTRL_OFFSET     = 4'h0;
    localparam logic [3:0]  STATUS_OFFSET   = 4'h4;
    localparam logic [31:0] CTRL_RESET      = 32'h0000_0000;
    localparam logic [31:0] CTRL_WMASK      = 32'h0001_FBF6;
    localparam int          UPPER_SEL_LSB   = 11;
    localparam int          LOWER_SEL_LSB   = 4;
    localparam int          USER_EN_BIT     = 2;
    localparam int          SUPER_EN_BIT    = 1;
    localparam int          SEL_W           = 6;
    localparam int          STAT_LOWER_BIT  = 0;
    localparam int          STAT_UPPER_BIT  = 1;
    localparam int          STAT_CAUSE_LSB  = 2;
    localparam int          STAT_L2_BIT     = 5;
    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;

    ////////////////////////////////////////////////////////////////////////////////
    // Event codes shared by both halves.
    localparam logic [5:0]  EV_CYCLES       = 6'h00;
    localparam logic [5:0]  EV_RETIRED      = 6'h01;
    // Lower half.
    localparam logic [5:0]  EVL_ICACHE_MISS = 6'h02;
    localparam logic [5:0]  EVL_TARGET_CALC = 6'h03;
    localparam logic [5:0]  EVL_SECOND_BR   = 6'h04;
    localparam logic [5:0]  EVL_STOREQ_FULL = 6'h05;
    localparam logic [5:0]  EVL_INT_USE     = 6'h06;
    localparam logic [5:0]  EVL_TAKEN_WRONG = 6'h15;
    localparam logic [5:0]  EVL_TAKEN       = 6'h16;
    localparam logic [5:0]  EVL_RSTACK_MISS = 6'h17;
    // Upper half.
    localparam logic [5:0]  EVU_MISPREDICT  = 6'h02;
    localparam logic [5:0]  EVU_FP_BYPASS   = 6'h05;
    localparam logic [5:0]  EVU_DC_MISS     = 6'h06;
    localparam logic [5:0]  EVU_L2_MISS     = 6'h07;
    localparam logic [5:0]  EVU_FP_USE      = 6'h0B;
    localparam logic [5:0]  EVU_PC_MISS     = 6'h10;
    localparam logic [5:0]  EVU_UNTKN_WRONG = 6'h1D;
    localparam logic [5:0]  EVU_UNTAKEN     = 6'h1E;
    localparam logic [5:0]  EVU_RAW_HAZARD  = 6'h26;

    typedef enum logic [2:0] {
        CAUSE_NONE,
        CAUSE_ICACHE,
        CAUSE_MISPRED,
        CAUSE_TARGET,
        CAUSE_RSTACK
    } pes_cause_e;

endpackage : pes_pkg

// [src/pes_event_select.sv]
// Design decisions made here: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/100ps

// What this block does
// - Code 00.0000 on either half counts every clock, gated only by mode enables.
// - Code 00.0001 counts retired instructions, excluding annulled, mispredicted, trapped, helper ones.
// - Upper 01.0000 counts recirculation stalls from prefetch-cache miss on predicted second load.
// - A branch is retired only when it reaches the final stage uninvalidated.
// - Lower 01.0101 counts retired branches predicted taken but not taken.
// - Upper 01.1101 counts retired branches predicted untaken but taken.
// - Lower 01.0110 counts retired taken branches; upper 01.1110 retired untaken ones.
// - Each fetch-side stall adds one count per cycle its condition holds.
// - Dispatch-empty events count whenever the queue is empty, regardless of pipeline readiness.
// - An empty cycle goes to at most one dispatch event, the latest disruptive cause; none before any cause is seen.
// - Lower 00.0010 counts empty-queue cycles after an instruction-cache miss, including L2 time.
// - Upper 00.0010 counts empty-queue cycles following a branch misprediction.
// - Lower 00.0011 counts empty-queue cycles during branch target calculation.
// - Lower 00.0100 counts stalls from two branches in one fetch group.
// - Lower 01.0111 counts empty-queue cycles after a return-stack misprediction.
// - Lower 00.0101 counts register-stage stalls of a store facing a full store queue.
// - Upper 00.1011 counts register-stage stalls waiting on a floating-point result.
// - Lower 00.0110 counts register-stage stalls waiting on an integer result.
// - Upper 10.0110 counts recirculation stalls from unbypassable load-after-store hazards.
// - Upper 00.0101 counts recirculation stalls from floating-point bypass without a path.
// - Upper 00.0110 counts stalls of cacheable loads missing both caches, recirculated.
// - Upper 00.0111 counts cycles from second-level miss detection to recirculated load's final stage.
// - Select bits 16:11 pick the upper event, bits 9:4 the lower event.
// - User enable gates non-privileged counting, supervisor enable privileged; both halves.
module pes_event_select (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        ce,
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        privileged_mode,
    input  wire logic        instr_retire,
    input  wire logic        instr_annulled,
    input  wire logic        instr_mispredicted,
    input  wire logic        instr_trapped,
    input  wire logic        instr_helper,
    input  wire logic        branch_final_stage,
    input  wire logic        branch_invalidated,
    input  wire logic        branch_predicted_taken,
    input  wire logic        branch_actual_taken,
    input  wire logic        queue_empty,
    input  wire logic        fetch_icache_miss,
    input  wire logic        fetch_mispredict,
    input  wire logic        fetch_target_calc,
    input  wire logic        fetch_return_stack_miss,
    input  wire logic        second_branch_refetch_stall,
    input  wire logic        store_queue_full_stall,
    input  wire logic        float_result_wait_stall,
    input  wire logic        integer_result_wait_stall,
    input  wire logic        load_store_hazard_recirc,
    input  wire logic        float_bypass_recirc,
    input  wire logic        dcache_miss_recirc,
    input  wire logic        second_level_miss_detect,
    input  wire logic        recirc_load_final_stage,
    input  wire logic        prefetch_miss_recirc,
    output logic             lower_count_inc_q,
    output logic             upper_count_inc_q
);

    ////////////////////////////////////////////////////////////////////////////////
    // Register slave.
    logic [31:0]         ctrl_q;
    logic [3:0]          aw_addr_q;
    logic [31:0]         w_data_q;
    logic [3:0]          w_strb_q;
    logic [31:0]         wmask;
    logic [31:0]         stat;
    logic [31:0]         rd_data;
    logic                rd_hit;
    logic                wr_fire;
    pes_pkg::pes_cause_e cause_q;
    pes_pkg::pes_cause_e cause_d;
    logic                l2_wait_q;

    assign wr_fire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            wmask[i*8 +: 8] = {8{w_strb_q[i]}};
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            aw_addr_q     <= 4'h0;
        end else if (ce) begin
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awready <= 1'b0;
                aw_addr_q     <= s_axi_awaddr;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_awready <= 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_wready <= 1'b1;
            w_data_q     <= 32'h0000_0000;
            w_strb_q     <= 4'h0;
        end else if (ce) begin
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wready <= 1'b0;
                w_data_q     <= s_axi_wdata;
                w_strb_q     <= s_axi_wstrb;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_wready <= 1'b1;
            end
        end
    end

    // Only the select and enable fields are writable; other bits stay zero.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q       <= pes_pkg::CTRL_RESET;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= pes_pkg::RESP_OKAY;
        end else if (ce) begin
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                if (aw_addr_q == pes_pkg::CTRL_OFFSET) begin
                    ctrl_q      <= (ctrl_q & ~(wmask & pes_pkg::CTRL_WMASK))
                                 | (w_data_q & wmask & pes_pkg::CTRL_WMASK);
                    s_axi_bresp <= pes_pkg::RESP_OKAY;
                end else if (aw_addr_q == pes_pkg::STATUS_OFFSET) begin
                    s_axi_bresp <= pes_pkg::RESP_OKAY;
                end else begin
                    s_axi_bresp <= pes_pkg::RESP_SLVERR;
                end
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_comb begin
        stat                                     = 32'h0000_0000;
        stat[pes_pkg::STAT_LOWER_BIT]            = lower_count_inc_q;
        stat[pes_pkg::STAT_UPPER_BIT]            = upper_count_inc_q;
        stat[pes_pkg::STAT_CAUSE_LSB +: 3]       = cause_q;
        stat[pes_pkg::STAT_L2_BIT]               = l2_wait_q;
        rd_hit                                   = 1'b1;
        if (s_axi_araddr == pes_pkg::CTRL_OFFSET) begin
            rd_data = ctrl_q;
        end else if (s_axi_araddr == pes_pkg::STATUS_OFFSET) begin
            rd_data = stat;
        end else begin
            rd_data = 32'h0000_0000;
            rd_hit  = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= pes_pkg::RESP_OKAY;
        end else if (ce) begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= rd_data;
                s_axi_rresp   <= rd_hit ? pes_pkg::RESP_OKAY : pes_pkg::RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_arready <= 1'b1;
                s_axi_rvalid  <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Event conditions.
    logic [5:0] lower_sel;
    logic [5:0] upper_sel;
    logic       count_en;
    logic       retired;
    logic       br_retired;
    logic       empty_icache;
    logic       empty_mispred;
    logic       empty_target;
    logic       empty_rstack;
    logic       l2_active;
    logic       lower_ev;
    logic       upper_ev;

    assign lower_sel = ctrl_q[pes_pkg::LOWER_SEL_LSB +: pes_pkg::SEL_W];
    assign upper_sel = ctrl_q[pes_pkg::UPPER_SEL_LSB +: pes_pkg::SEL_W];
    assign count_en  = privileged_mode ? ctrl_q[pes_pkg::SUPER_EN_BIT]
                                       : ctrl_q[pes_pkg::USER_EN_BIT];

    assign retired = instr_retire && !instr_annulled && !instr_mispredicted
                  && !instr_trapped && !instr_helper;
    assign br_retired = branch_final_stage && !branch_invalidated;

    // A cause seen this cycle already owns this cycle; simultaneous causes
    // resolve by fixed priority because the fetch unit gives no finer order.
    always_comb begin
        cause_d = cause_q;
        if (fetch_mispredict) begin
            cause_d = pes_pkg::CAUSE_MISPRED;
        end else if (fetch_return_stack_miss) begin
            cause_d = pes_pkg::CAUSE_RSTACK;
        end else if (fetch_icache_miss) begin
            cause_d = pes_pkg::CAUSE_ICACHE;
        end else if (fetch_target_calc) begin
            cause_d = pes_pkg::CAUSE_TARGET;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cause_q <= pes_pkg::CAUSE_NONE;
        end else if (ce) begin
            cause_q <= cause_d;
        end
    end

    // Pipeline readiness is deliberately not an input here.
    assign empty_icache  = queue_empty && cause_d == pes_pkg::CAUSE_ICACHE;
    assign empty_mispred = queue_empty && cause_d == pes_pkg::CAUSE_MISPRED;
    assign empty_target  = queue_empty && cause_d == pes_pkg::CAUSE_TARGET;
    assign empty_rstack  = queue_empty && cause_d == pes_pkg::CAUSE_RSTACK;

    // Miss detection wins over a same-cycle final-stage arrival.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            l2_wait_q <= 1'b0;
        end else if (ce) begin
            l2_wait_q <= second_level_miss_detect || (l2_wait_q && !recirc_load_final_stage);
        end
    end
    // The final-stage cycle is no longer a stall, so it closes the window uncounted.
    assign l2_active = second_level_miss_detect || (l2_wait_q && !recirc_load_final_stage);

    always_comb begin
        lower_ev = 1'b0;
        case (lower_sel)
            pes_pkg::EV_CYCLES:       lower_ev = 1'b1;
            pes_pkg::EV_RETIRED:      lower_ev = retired;
            pes_pkg::EVL_ICACHE_MISS: lower_ev = empty_icache;
            pes_pkg::EVL_TARGET_CALC: lower_ev = empty_target;
            pes_pkg::EVL_SECOND_BR:   lower_ev = second_branch_refetch_stall;
            pes_pkg::EVL_STOREQ_FULL: lower_ev = store_queue_full_stall;
            pes_pkg::EVL_INT_USE:     lower_ev = integer_result_wait_stall;
            pes_pkg::EVL_TAKEN_WRONG: lower_ev = br_retired && branch_predicted_taken && !branch_actual_taken;
            pes_pkg::EVL_TAKEN:       lower_ev = br_retired && branch_actual_taken;
            pes_pkg::EVL_RSTACK_MISS: lower_ev = empty_rstack;
            default:                  lower_ev = 1'b0;
        endcase
    end

    always_comb begin
        upper_ev = 1'b0;
        case (upper_sel)
            pes_pkg::EV_CYCLES:       upper_ev = 1'b1;
            pes_pkg::EV_RETIRED:      upper_ev = retired;
            pes_pkg::EVU_MISPREDICT:  upper_ev = empty_mispred;
            pes_pkg::EVU_FP_BYPASS:   upper_ev = float_bypass_recirc;
            pes_pkg::EVU_DC_MISS:     upper_ev = dcache_miss_recirc;
            pes_pkg::EVU_L2_MISS:     upper_ev = l2_active;
            pes_pkg::EVU_FP_USE:      upper_ev = float_result_wait_stall;
            pes_pkg::EVU_PC_MISS:     upper_ev = prefetch_miss_recirc;
            pes_pkg::EVU_UNTKN_WRONG: upper_ev = br_retired && !branch_predicted_taken && branch_actual_taken;
            pes_pkg::EVU_UNTAKEN:     upper_ev = br_retired && !branch_actual_taken;
            pes_pkg::EVU_RAW_HAZARD:  upper_ev = load_store_hazard_recirc;
            default:                  upper_ev = 1'b0;
        endcase
    end

    // One qualifier per clock, so each held stall cycle adds exactly one.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lower_count_inc_q <= 1'b0;
            upper_count_inc_q <= 1'b0;
        end else if (ce) begin
            lower_count_inc_q <= lower_ev && count_en;
            upper_count_inc_q <= upper_ev && count_en;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.
    property p_cycles;
        @(posedge aclk) disable iff (!aresetn)
        ce && count_en && lower_sel == pes_pkg::EV_CYCLES |=> lower_count_inc_q;
    endproperty
    a_cycles: assert property (p_cycles) else $error("Cycle event missed.");

    property p_retired;
        @(posedge aclk) disable iff (!aresetn)
        ce && count_en && upper_sel == pes_pkg::EV_RETIRED
            |=> upper_count_inc_q == $past(retired) && !($past(instr_trapped) && upper_count_inc_q);
    endproperty
    a_retired: assert property (p_retired) else $error("Retired count wrong.");

    property p_taken_wrong;
        @(posedge aclk) disable iff (!aresetn)
        ce && count_en && lower_sel == pes_pkg::EVL_TAKEN_WRONG && branch_invalidated |=> !lower_count_inc_q;
    endproperty
    a_taken_wrong: assert property (p_taken_wrong) else $error("Invalidated branch counted.");

    property p_untaken_wrong;
        @(posedge aclk) disable iff (!aresetn)
        ce && count_en && upper_sel == pes_pkg::EVU_UNTKN_WRONG && br_retired
            && !branch_predicted_taken && branch_actual_taken |=> upper_count_inc_q;
    endproperty
    a_untaken_wrong: assert property (p_untaken_wrong) else $error("Untaken mispredict missed.");

    property p_one_cause;
        @(posedge aclk) disable iff (!aresetn)
        queue_empty |-> $onehot0({empty_icache, empty_mispred, empty_target, empty_rstack});
    endproperty
    a_one_cause: assert property (p_one_cause) else $error("Empty cycle credited twice.");

    property p_disabled;
        @(posedge aclk) disable iff (!aresetn)
        ce && !count_en |=> !lower_count_inc_q && !upper_count_inc_q;
    endproperty
    a_disabled: assert property (p_disabled) else $error("Counted while disabled.");

    sequence s_l2_start;
        ce && second_level_miss_detect && !recirc_load_final_stage;
    endsequence
    sequence s_l2_hold;
        ce && !second_level_miss_detect && !recirc_load_final_stage;
    endsequence
    property p_l2_window;
        @(posedge aclk) disable iff (!aresetn)
        s_l2_start ##1 s_l2_hold |-> l2_active ##1 l2_wait_q;
    endproperty
    a_l2_window: assert property (p_l2_window) else $error("L2 miss window lost.");

    property p_l2_end;
        @(posedge aclk) disable iff (!aresetn)
        recirc_load_final_stage && !second_level_miss_detect |-> !l2_active;
    endproperty
    a_l2_end: assert property (p_l2_end) else $error("L2 window ran past the final stage.");

    property p_storeq;
        @(posedge aclk) disable iff (!aresetn)
        ce && count_en && lower_sel == pes_pkg::EVL_STOREQ_FULL && store_queue_full_stall
            ##1 ce && count_en && lower_sel == pes_pkg::EVL_STOREQ_FULL && store_queue_full_stall
            |=> lower_count_inc_q && $past(lower_count_inc_q);
    endproperty
    a_storeq: assert property (p_storeq) else $error("Stall cycle not counted.");

    property p_select;
        @(posedge aclk) disable iff (!aresetn)
        ce && count_en && upper_sel == pes_pkg::EVU_PC_MISS |=> upper_count_inc_q == $past(prefetch_miss_recirc);
    endproperty
    a_select: assert property (p_select) else $error("Upper select wrong.");

endmodule : pes_event_select

// [tb/pes_pipe_model.sv]
`timescale 1ns/100ps

// Stands in for the pipeline stages: each cue bit becomes one stage signal with no added delay.
// Kept flat on purpose so every stage condition can be set alone or together in any cycle.
module pes_pipe_model (
    input  wire logic [23:0] cue,
    output logic             instr_retire,
    output logic             instr_annulled,
    output logic             instr_mispredicted,
    output logic             instr_trapped,
    output logic             instr_helper,
    output logic             branch_final_stage,
    output logic             branch_invalidated,
    output logic             branch_predicted_taken,
    output logic             branch_actual_taken,
    output logic             queue_empty,
    output logic             fetch_icache_miss,
    output logic             fetch_mispredict,
    output logic             fetch_target_calc,
    output logic             fetch_return_stack_miss,
    output logic             second_branch_refetch_stall,
    output logic             store_queue_full_stall,
    output logic             float_result_wait_stall,
    output logic             integer_result_wait_stall,
    output logic             load_store_hazard_recirc,
    output logic             float_bypass_recirc,
    output logic             dcache_miss_recirc,
    output logic             second_level_miss_detect,
    output logic             recirc_load_final_stage,
    output logic             prefetch_miss_recirc
);
    assign {prefetch_miss_recirc, recirc_load_final_stage, second_level_miss_detect, dcache_miss_recirc,
            float_bypass_recirc, load_store_hazard_recirc, integer_result_wait_stall, float_result_wait_stall,
            store_queue_full_stall, second_branch_refetch_stall, fetch_return_stack_miss, fetch_target_calc,
            fetch_mispredict, fetch_icache_miss, queue_empty, branch_actual_taken, branch_predicted_taken,
            branch_invalidated, branch_final_stage, instr_helper, instr_trapped, instr_mispredicted,
            instr_annulled, instr_retire} = cue;
endmodule : pes_pipe_model

// [tb/pes_event_select_tb_top.sv]
`timescale 1ns/100ps

module pes_event_select_tb_top;
    logic        aclk, aresetn, ce, privileged_mode, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic        lower_count_inc_q, upper_count_inc_q;
    logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [23:0] cue;
    wire         instr_retire, instr_annulled, instr_mispredicted, instr_trapped, instr_helper, branch_final_stage;
    wire         branch_invalidated, branch_predicted_taken, branch_actual_taken, queue_empty, fetch_icache_miss;
    wire         fetch_mispredict, fetch_target_calc, fetch_return_stack_miss, second_branch_refetch_stall;
    wire         store_queue_full_stall, float_result_wait_stall, integer_result_wait_stall, dcache_miss_recirc;
    wire         load_store_hazard_recirc, float_bypass_recirc, second_level_miss_detect, recirc_load_final_stage;
    wire         prefetch_miss_recirc;
    int          failures, check_count;

    pes_pipe_model pes_pipe_model_inst (.*);
    pes_event_select pes_event_select_inst (.*);

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        chk(s_axi_bresp, er);
    endtask : wr

    task automatic rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        chk(s_axi_rdata, ed);
        chk(s_axi_rresp, er);
    endtask : rd

    // Selects the pair, holds the stage cue for n+1 cycles and checks each qualifier one edge later over the first n.
    task automatic ev(input logic [1:0] en, input logic pm, input logic [5:0] ls, input logic [5:0] us,
                      input logic [23:0] st, input int n, input logic el, input logic eu);
        wr(pes_pkg::CTRL_OFFSET, {15'h0000, us, 1'b0, ls, 1'b0, en, 1'b0}, pes_pkg::RESP_OKAY);
        privileged_mode <= pm;
        cue <= st;
        repeat (n) begin
            @(posedge aclk);
            #1;
            chk(lower_count_inc_q, el);
            chk(upper_count_inc_q, eu);
        end
        @(posedge aclk);
        cue <= 24'h000000;
    endtask : ev

    // The mode flips while ce is low, so the qualifiers must keep their last value until ce returns.
    task automatic frz();
        ev(2, 0, 6'h00, 6'h00, 24'h000000, 1, 1, 1);
        ce <= 1'b0;
        privileged_mode <= 1'b1;
        repeat (2) @(posedge aclk);
        #1;
        chk({lower_count_inc_q, upper_count_inc_q}, 32'h3);
        @(posedge aclk);
        ce <= 1'b1;
        @(posedge aclk);
        #1;
        chk({lower_count_inc_q, upper_count_inc_q}, 32'h0);
        @(posedge aclk);
    endtask : frz

    task automatic final_report();
        if (failures == 0 && check_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : final_report

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end

    // A few hundred cycles are expected; the limit leaves wide room for slow bus answers.
    initial begin
        #(40 * 5000);
        failures++;
        final_report();
    end

    initial begin
        {aresetn, privileged_mode, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 7'h00;
        ce = 1'b1;
        s_axi_wstrb = 4'hF;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, cue} = 64'h0;
        failures = 0;
        check_count = 0;
        repeat (20) @(posedge aclk);
        #1;
        chk({lower_count_inc_q, upper_count_inc_q}, 32'h0);
        @(posedge aclk);
        aresetn <= 1'b1;
        rd(pes_pkg::CTRL_OFFSET, 32'h0000_0000, pes_pkg::RESP_OKAY);
        wr(pes_pkg::CTRL_OFFSET, 32'hFFFF_FFFF, pes_pkg::RESP_OKAY);
        rd(pes_pkg::CTRL_OFFSET, 32'h0001_FBF6, pes_pkg::RESP_OKAY);
        wr(4'h8, 32'h0000_0006, pes_pkg::RESP_SLVERR);
        rd(4'h8, 32'h0000_0000, pes_pkg::RESP_SLVERR);
        ev(3, 0, 6'h00, 6'h00, 24'h000000, 3, 1, 1);
        ev(2, 1, 6'h00, 6'h00, 24'h000000, 1, 0, 0);
        ev(2, 0, 6'h00, 6'h00, 24'h000000, 1, 1, 1);
        ev(1, 0, 6'h00, 6'h00, 24'h000000, 1, 0, 0);
        ev(1, 1, 6'h00, 6'h00, 24'h000000, 1, 1, 1);
        ev(0, 1, 6'h00, 6'h00, 24'h000000, 1, 0, 0);
        ev(3, 0, 6'h01, 6'h01, 24'h000001, 2, 1, 1);
        for (int i = 1; i < 5; i++) ev(3, 0, 6'h01, 6'h01, 24'h000001 | (24'h000001 << i), 1, 0, 0);
        ev(3, 0, 6'h15, 6'h1D, 24'h0000A0, 1, 1, 0);
        ev(3, 0, 6'h15, 6'h1D, 24'h000120, 1, 0, 1);
        ev(3, 0, 6'h15, 6'h1D, 24'h0000E0, 1, 0, 0);
        ev(3, 0, 6'h16, 6'h1E, 24'h000120, 1, 1, 0);
        ev(3, 0, 6'h16, 6'h1E, 24'h000020, 1, 0, 1);
        ev(3, 0, 6'h16, 6'h1E, 24'h000160, 1, 0, 0);
        ev(3, 0, 6'h16, 6'h1E, 24'h000100, 1, 0, 0);
        ev(3, 0, 6'h02, 6'h02, 24'h000600, 1, 1, 0);
        ev(3, 0, 6'h02, 6'h02, 24'h000200, 2, 1, 0);
        ev(3, 0, 6'h02, 6'h02, 24'h000A00, 1, 0, 1);
        ev(3, 0, 6'h02, 6'h02, 24'h000000, 1, 0, 0);
        ev(3, 0, 6'h03, 6'h02, 24'h001200, 1, 1, 0);
        ev(3, 0, 6'h17, 6'h02, 24'h002200, 1, 1, 0);
        ev(3, 0, 6'h02, 6'h02, 24'h000200, 1, 0, 0);
        ev(3, 0, 6'h04, 6'h0B, 24'h004000, 3, 1, 0);
        ev(3, 0, 6'h05, 6'h0B, 24'h010000, 1, 0, 1);
        ev(3, 0, 6'h05, 6'h26, 24'h008000, 1, 1, 0);
        ev(3, 0, 6'h06, 6'h26, 24'h040000, 1, 0, 1);
        ev(3, 0, 6'h06, 6'h05, 24'h020000, 1, 1, 0);
        ev(3, 0, 6'h06, 6'h05, 24'h080000, 1, 0, 1);
        ev(3, 0, 6'h3F, 6'h06, 24'h100000, 1, 0, 1);
        ev(3, 0, 6'h3F, 6'h10, 24'h800000, 1, 0, 1);
        ev(3, 0, 6'h3F, 6'h07, 24'h200000, 1, 0, 1);
        ev(3, 0, 6'h3F, 6'h07, 24'h000000, 2, 0, 1);
        ev(3, 0, 6'h3F, 6'h07, 24'h400000, 1, 0, 0);
        ev(3, 0, 6'h3F, 6'h3F, 24'hFFFFFF, 1, 0, 0);
        frz();
        rd(pes_pkg::STATUS_OFFSET, 32'h0000_0028, pes_pkg::RESP_OKAY);
        final_report();
    end
endmodule : pes_event_select_tb_top
